// ===== design/qpc_pkg.sv
// quad phase core package: constants, opcodes, alu operations
package qpc_pkg;
	localparam int          PH_COUNT   = 4;
	localparam int          PC_W       = 9;
	localparam int          IW         = 12;
	localparam int          DW         = 8;
	localparam int          FA_W       = 5;
	localparam int          NPIN       = 4;
	localparam int          RST_PIN    = 3;
	localparam logic [3:0]  PH_RESET   = 4'h1;
	localparam logic [8:0]  PC_RESET   = 9'h000;
	localparam logic [8:0]  PC_ONE     = 9'h001;
	localparam logic [8:0]  PC_MASK_SM = 9'h0FF;
	localparam logic [8:0]  PC_MASK_LG = 9'h1FF;
	localparam logic [4:0]  F_INDIRECT = 5'h00;
	localparam logic [4:0]  F_CNT_LOW  = 5'h02;
	localparam logic [4:0]  F_STATUS   = 5'h03;
	localparam logic [4:0]  F_FSEL     = 5'h04;
	localparam logic [7:0]  FSEL_RESET = 8'hE0;
	localparam logic [1:0]  ST_TOPD    = 2'h3;
	localparam logic [2:0]  ST_HI_RST  = 3'h0;
	localparam int          ST_PAGE    = 0;
	// flag vector order is zero, half carry, carry
	localparam int          FL_Z       = 2;
	localparam int          FL_HC      = 1;
	localparam int          FL_C       = 0;
	localparam int          D_BIT      = 5;
	localparam logic [3:0]  OP_NOP     = 4'h0;
	localparam logic [3:0]  OP_MOVWF   = 4'h1;
	localparam logic [3:0]  OP_MOVF    = 4'h2;
	localparam logic [3:0]  OP_ADDWF   = 4'h3;
	localparam logic [3:0]  OP_SUBWF   = 4'h4;
	localparam logic [3:0]  OP_ANDWF   = 4'h5;
	localparam logic [3:0]  OP_IORWF   = 4'h6;
	localparam logic [3:0]  OP_XORWF   = 4'h7;
	localparam logic [3:0]  OP_RLF     = 4'h8;
	localparam logic [3:0]  OP_RRF     = 4'h9;
	localparam logic [3:0]  OP_CLRF    = 4'hA;
	localparam logic [3:0]  OP_MOVLW   = 4'hB;
	localparam logic [3:0]  OP_ANDLW   = 4'hC;
	localparam logic [3:0]  OP_IORLW   = 4'hD;
	localparam logic [3:0]  OP_XORLW   = 4'hE;
	localparam logic [3:0]  OP_JUMP    = 4'hF;
	localparam logic [2:0]  REG_CTRL   = 3'h0;
	localparam logic [2:0]  REG_PINCFG = 3'h1;
	localparam logic [2:0]  REG_CORE   = 3'h2;
	localparam logic [2:0]  REG_INSTR  = 3'h3;
	localparam int          CT_EXTRST  = 0;
	localparam int          CT_LARGE   = 1;
	localparam logic [1:0]  CTRL_RESET = 2'h2;
	localparam int          PU_LO      = 0;
	localparam int          WK_LO      = 8;
	typedef enum logic [3:0] {
		ALU_PASS_B = 4'h0,
		ALU_PASS_A = 4'h1,
		ALU_ADD    = 4'h2,
		ALU_SUB    = 4'h3,
		ALU_AND    = 4'h4,
		ALU_OR     = 4'h5,
		ALU_XOR    = 4'h6,
		ALU_RL     = 4'h7,
		ALU_RR     = 4'h8,
		ALU_CLR    = 4'h9
	} qpc_alu_op_t;
endpackage

// ===== design/qpc_phase.sv
// quad phase generator: one-hot divide by four
`timescale 1ns/1ps
module qpc_phase
	import qpc_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	output logic      phase_one_o,
	output logic      phase_two_o,
	output logic      phase_three_o,
	output logic      phase_four_o
);
	logic [PH_COUNT-1:0] ph_q;

	// rotating token keeps the phases non-overlapping by construction
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ph_q <= PH_RESET;
		end else begin
			ph_q <= {ph_q[PH_COUNT-2:0], ph_q[PH_COUNT-1]};
		end
	end

	assign phase_one_o   = ph_q[0];
	assign phase_two_o   = ph_q[1];
	assign phase_three_o = ph_q[2];
	assign phase_four_o  = ph_q[3];

	a_phase_onehot: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$onehot(ph_q)) else $error("phase token not one-hot");
	a_phase_order: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		phase_one_o |=> phase_two_o ##1 phase_three_o ##1 phase_four_o ##1 phase_one_o)
		else $error("phase sequence broken");
endmodule

// ===== design/qpc_alu.sv
// eight bit alu with carry, half carry and zero
`timescale 1ns/1ps
module qpc_alu
	import qpc_pkg::*;
(
	input  wire qpc_alu_op_t   op_i,
	input  wire logic [DW-1:0] a_i,
	input  wire logic [DW-1:0] b_i,
	input  wire logic          c_i,
	output logic [DW-1:0]      res_o,
	output logic [2:0]         flags_o
);
	logic [DW:0] sum;
	logic [4:0]  nib;

	// a is the accumulator, b the file or literal operand
	always_comb begin
		sum = '0;
		nib = '0;
		res_o = b_i;
		flags_o = '0;
		flags_o[FL_C] = c_i;
		unique case (op_i)
			ALU_PASS_B: res_o = b_i;
			ALU_PASS_A: res_o = a_i;
			ALU_ADD: begin
				sum = {1'b0, a_i} + {1'b0, b_i};
				nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
				res_o = sum[DW-1:0];
				flags_o[FL_C] = sum[DW];
				flags_o[FL_HC] = nib[4];
			end
			ALU_SUB: begin
				// file minus accumulator; flags mean no borrow
				res_o = b_i - a_i;
				flags_o[FL_C] = (b_i >= a_i);
				flags_o[FL_HC] = (b_i[3:0] >= a_i[3:0]);
			end
			ALU_AND: res_o = a_i & b_i;
			ALU_OR:  res_o = a_i | b_i;
			ALU_XOR: res_o = a_i ^ b_i;
			ALU_RL: begin
				res_o = {b_i[DW-2:0], c_i};
				flags_o[FL_C] = b_i[DW-1];
			end
			ALU_RR: begin
				res_o = {c_i, b_i[DW-1:1]};
				flags_o[FL_C] = b_i[0];
			end
			ALU_CLR: res_o = '0;
		endcase
		flags_o[FL_Z] = (res_o == '0);
	end
endmodule

// ===== design/qpc_core.sv
// two stage quad phase core sequencer with register slave
`timescale 1ns/1ps
module qpc_core
	import qpc_pkg::*;
(
	input  wire logic            clk_sys_i,
	input  wire logic            rst_i,
	input  wire logic [2:0]      avs_address_i,
	input  wire logic            avs_read_i,
	input  wire logic            avs_write_i,
	input  wire logic [31:0]     avs_writedata_i,
	input  wire logic [3:0]      avs_byteenable_i,
	output logic [31:0]          avs_readdata_o,
	output logic                 avs_waitrequest_o,
	output logic [PC_W-1:0]      prog_addr_o,
	input  wire logic [IW-1:0]   prog_data_i,
	output logic [FA_W-1:0]      dmem_addr_o,
	output logic                 dmem_re_o,
	input  wire logic [DW-1:0]   dmem_rdata_i,
	output logic                 dmem_we_o,
	output logic [DW-1:0]        dmem_wdata_o,
	input  wire logic [NPIN-1:0] gp_i,
	output logic [NPIN-1:0]      pullup_en_o,
	output logic [NPIN-1:0]      wake_en_o,
	output logic                 wake_evt_o
);
	logic            phase_one;
	logic            phase_two;
	logic            phase_three;
	logic            phase_four;
	logic            core_rst;
	logic            ext_reset_q;
	logic [NPIN-1:0] gp_s1_q;
	logic [NPIN-1:0] gp_s2_q;
	logic [NPIN-1:0] gp_s3_q;
	logic [1:0]      ctrl_q;
	logic [NPIN-1:0] pu_q;
	logic [NPIN-1:0] wk_q;
	logic            wait_q;
	logic [31:0]     rd_mux;
	logic [PC_W-1:0] program_counter_q;
	logic [PC_W-1:0] pc_mask;
	logic [PC_W-1:0] pc_inc;
	logic [PC_W-1:0] jump_tgt;
	logic [IW-1:0]   ir_q;
	logic            ir_valid_q;
	logic [DW-1:0]   acc_q;
	logic [DW-1:0]   fsel_q;
	logic [2:0]      st_hi_q;
	logic [2:0]      flags_q;
	logic [2:0]      rflags_q;
	logic [DW-1:0]   opnd_q;
	logic [DW-1:0]   alu_res;
	logic [2:0]      alu_flags;
	logic [DW-1:0]   src_val;
	logic [DW-1:0]   status_val;
	logic [3:0]      opc;
	logic [FA_W-1:0] eff_addr;
	logic            internal;
	qpc_alu_op_t     alu_op;
	logic            use_lit;
	logic            reads_f;
	logic            to_file;
	logic            to_acc;
	logic            is_jump;
	logic [2:0]      aff;
	logic            exec;
	logic            cnt_wr;
	logic            branch;

	qpc_phase u_phase (
		.clk_sys_i     (clk_sys_i),
		.rst_i         (core_rst),
		.phase_one_o   (phase_one),
		.phase_two_o   (phase_two),
		.phase_three_o (phase_three),
		.phase_four_o  (phase_four)
	);

	qpc_alu u_alu (
		.op_i    (alu_op),
		.a_i     (acc_q),
		.b_i     (opnd_q),
		.c_i     (flags_q[FL_C]),
		.res_o   (alu_res),
		.flags_o (alu_flags)
	);

	// pin synchroniser; third stage only feeds change detection
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			gp_s1_q <= '0;
			gp_s2_q <= '0;
			gp_s3_q <= '0;
		end else begin
			gp_s1_q <= gp_i;
			gp_s2_q <= gp_s1_q;
			gp_s3_q <= gp_s2_q;
		end
	end

	// reset pin, only when configured; adds one cycle of latency
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ext_reset_q <= 1'b0;
		end else begin
			ext_reset_q <= ctrl_q[CT_EXTRST] & ~gp_s2_q[RST_PIN];
		end
	end

	assign core_rst = rst_i | ext_reset_q;

	// pad controls; in reset pin mode the reset pin keeps its pull-up whatever pincfg says
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pullup_en_o <= '0;
			wake_en_o <= '0;
			wake_evt_o <= 1'b0;
		end else begin
			pullup_en_o <= pu_q;
			pullup_en_o[RST_PIN] <= pu_q[RST_PIN] | ctrl_q[CT_EXTRST];
			wake_en_o <= wk_q;
			wake_evt_o <= |((gp_s2_q ^ gp_s3_q) & wk_q);
		end
	end

	// bus handshake: one wait cycle, then the answer edge
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
		end
	end

	assign avs_waitrequest_o = wait_q;

	// read mux; unmapped words read as zero
	always_comb begin
		rd_mux = '0;
		unique case (avs_address_i)
			REG_CTRL: rd_mux[1:0] = ctrl_q;
			REG_PINCFG: begin
				rd_mux[PU_LO+:NPIN] = pu_q;
				rd_mux[WK_LO+:NPIN] = wk_q;
			end
			REG_CORE:  rd_mux = {7'h00, program_counter_q, acc_q, status_val};
			REG_INSTR: rd_mux = {19'h0_0000, ir_valid_q, ir_q};
			default:   rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			avs_readdata_o <= '0;
		end else if (avs_read_i && wait_q) begin
			avs_readdata_o <= rd_mux;
		end
	end

	// writes land at the edge where waitrequest is seen low
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RESET;
			pu_q <= '0;
			wk_q <= '0;
		end else if (avs_write_i && !wait_q) begin
			if (avs_address_i == REG_CTRL && avs_byteenable_i[0]) begin
				ctrl_q <= avs_writedata_i[1:0];
			end
			if (avs_address_i == REG_PINCFG && avs_byteenable_i[0]) begin
				pu_q <= avs_writedata_i[PU_LO+:NPIN];
			end
			if (avs_address_i == REG_PINCFG && avs_byteenable_i[1]) begin
				wk_q <= avs_writedata_i[WK_LO+:NPIN];
			end
		end
	end

	// decode of the latched word
	always_comb begin
		opc = ir_q[IW-1:IW-4];
		alu_op = ALU_PASS_B;
		use_lit = 1'b0;
		reads_f = 1'b1;
		to_file = ir_q[D_BIT];
		to_acc = ~ir_q[D_BIT];
		is_jump = 1'b0;
		aff = 3'h0;
		unique case (opc)
			OP_NOP: begin
				reads_f = 1'b0;
				to_file = 1'b0;
				to_acc = 1'b0;
			end
			OP_MOVWF: begin
				alu_op = ALU_PASS_A;
				reads_f = 1'b0;
				to_file = 1'b1;
				to_acc = 1'b0;
			end
			OP_MOVF:  aff[FL_Z] = 1'b1;
			OP_ADDWF: begin
				alu_op = ALU_ADD;
				aff = 3'h7;
			end
			OP_SUBWF: begin
				alu_op = ALU_SUB;
				aff = 3'h7;
			end
			OP_ANDWF: {alu_op, aff[FL_Z]} = {ALU_AND, 1'b1};
			OP_IORWF: {alu_op, aff[FL_Z]} = {ALU_OR, 1'b1};
			OP_XORWF: {alu_op, aff[FL_Z]} = {ALU_XOR, 1'b1};
			OP_RLF:   {alu_op, aff[FL_C]} = {ALU_RL, 1'b1};
			OP_RRF:   {alu_op, aff[FL_C]} = {ALU_RR, 1'b1};
			OP_CLRF: begin
				alu_op = ALU_CLR;
				reads_f = 1'b0;
				aff[FL_Z] = 1'b1;
			end
			OP_MOVLW, OP_ANDLW, OP_IORLW, OP_XORLW: begin
				use_lit = 1'b1;
				reads_f = 1'b0;
				to_file = 1'b0;
				to_acc = 1'b1;
				aff[FL_Z] = (opc != OP_MOVLW);
				alu_op = (opc == OP_ANDLW) ? ALU_AND :
					(opc == OP_IORLW) ? ALU_OR :
					(opc == OP_XORLW) ? ALU_XOR : ALU_PASS_B;
			end
			OP_JUMP: begin
				is_jump = 1'b1;
				reads_f = 1'b0;
				to_file = 1'b0;
				to_acc = 1'b0;
			end
		endcase
	end

	// file address 0 goes through the select pointer
	assign eff_addr = (ir_q[FA_W-1:0] == F_INDIRECT) ? fsel_q[FA_W-1:0] : ir_q[FA_W-1:0];
	assign internal = (eff_addr == F_CNT_LOW) || (eff_addr == F_STATUS) ||
		(eff_addr == F_FSEL);
	assign status_val = {st_hi_q, ST_TOPD, flags_q};
	assign exec = ir_valid_q;
	assign cnt_wr = to_file && (eff_addr == F_CNT_LOW);
	assign branch = exec && (is_jump || cnt_wr);

	// core registers sit in the data space ahead of the external file
	always_comb begin
		unique case (eff_addr)
			F_CNT_LOW: src_val = program_counter_q[DW-1:0];
			F_STATUS:  src_val = status_val;
			F_FSEL:    src_val = fsel_q;
			default:   src_val = dmem_rdata_i;
		endcase
	end

	// wrap within the implemented program space
	assign pc_mask = ctrl_q[CT_LARGE] ? PC_MASK_LG : PC_MASK_SM;
	assign pc_inc = PC_W'(program_counter_q + PC_ONE) & pc_mask;
	assign jump_tgt = {st_hi_q[ST_PAGE], ir_q[DW-1:0]} & pc_mask;

	// counter steps at phase one; a branch overrides it at phase four
	always_ff @(posedge clk_sys_i) begin
		if (core_rst) begin
			program_counter_q <= PC_RESET;
		end else if (phase_four && branch) begin
			program_counter_q <= is_jump ? jump_tgt : ({1'b0, dmem_wdata_o} & pc_mask);
		end else if (phase_one) begin
			program_counter_q <= pc_inc;
		end
	end

	// fetch runs alongside execute of the previous word
	always_ff @(posedge clk_sys_i) begin
		if (core_rst) begin
			prog_addr_o <= PC_RESET;
		end else if (phase_one) begin
			prog_addr_o <= program_counter_q;
		end
	end

	// empty after reset, so the first cycle only fetches
	always_ff @(posedge clk_sys_i) begin
		if (core_rst) begin
			ir_q <= '0;
			ir_valid_q <= 1'b0;
		end else if (phase_four) begin
			ir_q <= prog_data_i;
			ir_valid_q <= ~branch;
		end
	end

	// operand read strobe spans phase two only
	always_ff @(posedge clk_sys_i) begin
		if (core_rst) begin
			dmem_addr_o <= '0;
			dmem_re_o <= 1'b0;
			opnd_q <= '0;
		end else if (phase_one) begin
			dmem_addr_o <= eff_addr;
			dmem_re_o <= exec && reads_f && !internal;
		end else if (phase_two) begin
			dmem_re_o <= 1'b0;
			opnd_q <= use_lit ? ir_q[DW-1:0] : src_val;
		end
	end

	// result formed in phase three, write strobe spans phase four
	always_ff @(posedge clk_sys_i) begin
		if (core_rst) begin
			dmem_wdata_o <= '0;
			dmem_we_o <= 1'b0;
			rflags_q <= '0;
		end else if (phase_three) begin
			dmem_wdata_o <= alu_res;
			rflags_q <= alu_flags;
			dmem_we_o <= exec && to_file && !internal;
		end else if (phase_four) begin
			dmem_we_o <= 1'b0;
		end
	end

	// accumulator has no data address
	always_ff @(posedge clk_sys_i) begin
		if (core_rst) begin
			acc_q <= '0;
		end else if (phase_four && exec && to_acc) begin
			acc_q <= dmem_wdata_o;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (core_rst) begin
			fsel_q <= FSEL_RESET;
		end else if (phase_four && exec && to_file && eff_addr == F_FSEL) begin
			fsel_q <= dmem_wdata_o;
		end
	end

	// flags the instruction owns win over a write to status
	always_ff @(posedge clk_sys_i) begin
		if (core_rst) begin
			st_hi_q <= ST_HI_RST;
			flags_q <= '0;
		end else if (phase_four && exec) begin
			if (to_file && eff_addr == F_STATUS) begin
				st_hi_q <= dmem_wdata_o[DW-1:DW-3];
			end
			for (int i = 0; i < 3; i++) begin
				if (aff[i]) begin
					flags_q[i] <= rflags_q[i];
				end else if (to_file && eff_addr == F_STATUS) begin
					flags_q[i] <= dmem_wdata_o[i];
				end
			end
		end
	end

	a_pc_advance: assert property (@(posedge clk_sys_i) disable iff (core_rst)
		phase_one |=> program_counter_q == $past(pc_inc))
		else $error("counter did not step at phase one");
	a_ir_capture: assert property (@(posedge clk_sys_i) disable iff (core_rst)
		phase_four |=> ir_q == $past(prog_data_i))
		else $error("instruction not latched at phase four");
	a_read_phase: assert property (@(posedge clk_sys_i) disable iff (core_rst)
		dmem_re_o |-> phase_two && $past(phase_one))
		else $error("operand read outside phase two");
	a_write_phase: assert property (@(posedge clk_sys_i) disable iff (core_rst)
		dmem_we_o |-> phase_four ##1 !dmem_we_o)
		else $error("destination write outside phase four");
	// the flushed word must stay invalid and strobe no write for a whole cycle
	a_branch_flush: assert property (@(posedge clk_sys_i) disable iff (core_rst)
		phase_four && exec && is_jump |=> (!ir_valid_q && !dmem_we_o)[*4])
		else $error("fetched word not flushed on branch");
	a_jump_target: assert property (@(posedge clk_sys_i) disable iff (core_rst)
		phase_four && exec && is_jump |=> program_counter_q == $past(jump_tgt)
		##1 prog_addr_o == $past(program_counter_q)) else $error("jump target lost");
	a_reset_vector: assert property (@(posedge clk_sys_i)
		core_rst |=> program_counter_q == PC_RESET && !ir_valid_q && phase_one)
		else $error("reset did not restart at zero");
	a_sub_borrow: assert property (@(posedge clk_sys_i) disable iff (core_rst)
		alu_op == ALU_SUB |-> alu_flags[FL_C] == (opnd_q >= acc_q))
		else $error("subtract carry is not inverted borrow");
	a_reset_pullup: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ctrl_q[CT_EXTRST] ##1 ctrl_q[CT_EXTRST] |-> pullup_en_o[RST_PIN])
		else $error("reset pin pull-up not forced");
endmodule

// ===== verif/qpc_mem_model.sv
// partner model: program flash and data register file
`timescale 1ns/1ps
module qpc_mem_model
	import qpc_pkg::*;
(
	input  wire logic            clk_sys_i,
	input  wire logic [PC_W-1:0] prog_addr_i,
	output logic [IW-1:0]        prog_data_o,
	input  wire logic [FA_W-1:0] dmem_addr_i,
	input  wire logic            dmem_re_i,
	output logic [DW-1:0]        dmem_rdata_o,
	input  wire logic            dmem_we_i,
	input  wire logic [DW-1:0]   dmem_wdata_i
);
	logic [IW-1:0] prog_q [512];
	logic [DW-1:0] file_q [32];
	logic [DW-1:0] last_q = 8'h00;
	// one clock access time, well inside the three the core allows
	always_ff @(posedge clk_sys_i) begin
		prog_data_o <= prog_q[prog_addr_i];
	end
	// write lands at the strobe edge; remember bus value for junk pattern
	always_ff @(posedge clk_sys_i) begin
		if (dmem_we_i) begin
			file_q[dmem_addr_i] <= dmem_wdata_i;
		end
		last_q <= dmem_rdata_o;
	end
	// outside a read strobe the bus inverts its last value each clock, so the stale byte returns every second clock
	assign dmem_rdata_o = dmem_re_i ? file_q[dmem_addr_i] : ~last_q;
endmodule

// ===== verif/qpc_core_bench.sv
// self-checking bench: program flow, register access, pin control
`timescale 1ns/1ps
module qpc_core_bench
	import qpc_pkg::*;
;
	localparam int   LIMIT = 4000;
	logic            clk_sys_i = 1'b0;
	logic            rst_i = 1'b1;
	logic [2:0]      avs_address_i = 3'h0;
	logic            avs_read_i = 1'b0;
	logic            avs_write_i = 1'b0;
	logic [31:0]     avs_writedata_i = 32'h0000_0000;
	logic [3:0]      avs_byteenable_i = 4'hf;
	logic [31:0]     avs_readdata_o;
	logic            avs_waitrequest_o;
	logic [PC_W-1:0] prog_addr_o;
	logic [IW-1:0]   prog_data_i;
	logic [FA_W-1:0] dmem_addr_o;
	logic            dmem_re_o;
	logic [DW-1:0]   dmem_rdata_i;
	logic            dmem_we_o;
	logic [DW-1:0]   dmem_wdata_o;
	logic [NPIN-1:0] gp_i = 4'h8;
	logic [NPIN-1:0] pullup_en_o;
	logic [NPIN-1:0] wake_en_o;
	logic            wake_evt_o;
	int              n_mismatch = 0;
	int              n_tests = 0;
	int              cyc = 0;
	int              n_wake = 0;
	int              k;
	logic [31:0]     rd;
	int              addr_t[$];
	logic [PC_W-1:0] addr_q[$];
	logic [12:0]     wr_q[$];
	logic [PC_W-1:0] last_addr = 9'h000;
	// load, store, load, add, subtract, jump over two stores, clear w, spin
	int              prog[10] = '{'hb3c, 'h130, 'hb05, 'h310, 'h430, 'hf08, 'h131, 'h131,
		'hc00, 'hf09};

	always #2.5 clk_sys_i = ~clk_sys_i;

	qpc_core uut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i), .dmem_addr_o(dmem_addr_o),
		.dmem_re_o(dmem_re_o), .dmem_rdata_i(dmem_rdata_i), .dmem_we_o(dmem_we_o),
		.dmem_wdata_o(dmem_wdata_o), .gp_i(gp_i), .pullup_en_o(pullup_en_o),
		.wake_en_o(wake_en_o), .wake_evt_o(wake_evt_o)
	);

	qpc_mem_model mem (
		.clk_sys_i(clk_sys_i), .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i),
		.dmem_addr_i(dmem_addr_o), .dmem_re_i(dmem_re_o), .dmem_rdata_o(dmem_rdata_i),
		.dmem_we_i(dmem_we_o), .dmem_wdata_i(dmem_wdata_o)
	);

	// log fetch address steps, data writes and wake pulses; cut hangs short
	always @(posedge clk_sys_i) begin
		cyc++;
		if (!rst_i && prog_addr_o !== last_addr) begin
			addr_q.push_back(prog_addr_o);
			addr_t.push_back(cyc);
			last_addr = prog_addr_o;
		end
		if (dmem_we_o === 1'b1) wr_q.push_back({dmem_addr_o, dmem_wdata_o});
		if (wake_evt_o === 1'b1) n_wake++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one avalon access; waits for waitrequest low, bounded, then settles
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		avs_read_i <= !wr;
		avs_write_i <= wr;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 40);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n >= 40) n_mismatch++;
		repeat (2) @(posedge clk_sys_i);
	endtask

	// expected fetch trace and data writes of the test program
	task automatic run_chk();
		int exp_a[11] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 9, 10};
		int n;
		n = 0;
		while (addr_q.size() < 11 && n < 200) begin
			@(posedge clk_sys_i);
			n++;
		end
		for (int i = 0; i < 11; i++) begin
			check("fetch address", 32'(addr_q[i]), 32'(exp_a[i]));
			if (i > 0) check("fetch spacing", 32'(addr_t[i] - addr_t[i-1]), 32'h0000_0004);
		end
		check("write count", 32'(wr_q.size()), 32'h0000_0002);
		check("first write", 32'(wr_q[0]), 32'h0000_103c);
		check("second write", 32'(wr_q[1]), 32'h0000_10fb);
		bus(1'b0, REG_CORE, 32'h0000_0000, 4'hf);
		check("w and status", 32'(rd[15:0]), 32'h0000_001e);
	endtask

	task automatic close_out();
		$display("TB: tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		for (int i = 0; i < 512; i++) begin
			mem.prog_q[i] = (i < 10) ? 12'(prog[i]) : 12'h000;
		end
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		run_chk();
		$display("test pipeline done");

		bus(1'b0, REG_CTRL, 32'h0000_0000, 4'hf);
		check("ctrl reset", rd, 32'h0000_0002);
		bus(1'b0, REG_PINCFG, 32'h0000_0000, 4'hf);
		check("pincfg reset", rd, 32'h0000_0000);
		bus(1'b1, 3'h5, 32'hffff_ffff, 4'hf);
		bus(1'b0, 3'h5, 32'h0000_0000, 4'hf);
		check("unmapped read", rd, 32'h0000_0000);
		bus(1'b1, REG_CORE, 32'h0000_ff00, 4'hf);
		bus(1'b0, REG_CORE, 32'h0000_0000, 4'hf);
		check("w not writable", 32'(rd[15:8]), 32'h0000_0000);
		$display("test registers done");

		bus(1'b1, REG_PINCFG, 32'h0000_0f05, 4'hf);
		check("pull-ups", 32'(pullup_en_o), 32'h0000_0005);
		check("wake enables", 32'(wake_en_o), 32'h0000_000f);
		bus(1'b1, REG_PINCFG, 32'h0000_0000, 4'h1);
		check("byte0 only", 32'({pullup_en_o, wake_en_o}), 32'h0000_000f);
		k = n_wake;
		gp_i <= 4'h9;
		repeat (8) @(posedge clk_sys_i);
		check("wake pulse", 32'(n_wake - k), 32'h0000_0001);
		bus(1'b1, REG_PINCFG, 32'h0000_0d00, 4'h2);
		k = n_wake;
		gp_i <= 4'hb;
		repeat (8) @(posedge clk_sys_i);
		check("masked wake", 32'(n_wake - k), 32'h0000_0000);
		$display("test pins done");

		// pull-up bit3 is off in pincfg, so only the reset pin mode can set it
		bus(1'b1, REG_CTRL, 32'h0000_0003, 4'hf);
		check("forced pull-up", 32'(pullup_en_o[RST_PIN]), 32'h0000_0001);
		gp_i <= 4'h3;
		repeat (12) @(posedge clk_sys_i);
		check("pin reset pc", 32'(prog_addr_o), 32'h0000_0000);
		addr_q.delete();
		addr_t.delete();
		wr_q.delete();
		gp_i <= 4'hb;
		run_chk();
		$display("test reset pin done");
		close_out();
	end
endmodule
